// file: logic/rcs_defines.vh
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH

// Program counter and vectors
`define RCS_PC_W        13
`define RCS_IR_W        14
`define RCS_RESET_VEC   13'h0000
`define RCS_INT_VEC     13'h0001
`define RCS_PC_ONE      13'h0001
`define RCS_PC_TWO      13'h0002

// Hardware stack
`define RCS_STK_DEPTH   6
`define RCS_STK_PTR_W   3
`define RCS_STK_LAST    3'h5

// Status register bit positions and reset values
`define RCS_ST_C        0
`define RCS_ST_NIB      1
`define RCS_ST_Z        2
`define RCS_ST_BANK     4
`define RCS_ST_PAGE     6
`define RCS_STATUS_RST  8'h00
`define RCS_PTR_RST     8'h00
`define RCS_W_RST       8'h00

// File plane addresses held inside the core
`define RCS_ADDR_IND    7'h00
`define RCS_ADDR_PCL    7'h02
`define RCS_ADDR_STATUS 7'h03
`define RCS_ADDR_PTR    7'h04

// Control forms of byte opcode 0 with destination 0
`define RCS_F_NOP       7'h00
`define RCS_F_SLEEP     7'h03
`define RCS_F_WDTCLR    7'h04
`define RCS_F_RET       7'h40
`define RCS_F_IRET      7'h60

// Byte opcodes, bits 11:8
`define RCS_OP_MOVE     4'h0
`define RCS_OP_CLR      4'h1
`define RCS_OP_SUB      4'h2
`define RCS_OP_DEC      4'h3
`define RCS_OP_IOR      4'h4
`define RCS_OP_AND      4'h5
`define RCS_OP_XOR      4'h6
`define RCS_OP_ADD      4'h7
`define RCS_OP_MOVF     4'h8
`define RCS_OP_COM      4'h9
`define RCS_OP_INC      4'ha
`define RCS_OP_DECSZ    4'hb
`define RCS_OP_RR       4'hc
`define RCS_OP_RL       4'hd
`define RCS_OP_SWAP     4'he
`define RCS_OP_INCSZ    4'hf

// Literal opcodes, bits 10:8
`define RCS_LIT_RET     3'h0
`define RCS_LIT_MOV     3'h1
`define RCS_LIT_IOR     3'h2
`define RCS_LIT_AND     3'h3
`define RCS_LIT_ADD     3'h4
`define RCS_LIT_XOR     3'h7

`endif

// file: logic/rcs_stack.v
`default_nettype none
`include "rcs_defines.vh"

module rcs_stack (
  // Clock and reset
  input  wire                      i_sys_clk,
  input  wire                      i_reset_n,
  // Push and pop strobes
  input  wire                      i_push,
  input  wire                      i_pop,
  input  wire [`RCS_PC_W-1:0]      i_push_data,
  // Top entry
  output wire [`RCS_PC_W-1:0]      o_top
);

  reg  [`RCS_STK_PTR_W-1:0] ptr_r;
  wire [`RCS_STK_PTR_W-1:0] ptr_up;
  wire [`RCS_STK_PTR_W-1:0] ptr_dn;
  wire [`RCS_PC_W-1:0]      entry [0:`RCS_STK_DEPTH-1];

  // Circular pointer: overflow silently overwrites the oldest entry
  assign ptr_up = (ptr_r == `RCS_STK_LAST) ? {`RCS_STK_PTR_W{1'b0}} : ptr_r + 3'h1;
  assign ptr_dn = (ptr_r == 3'h0) ? `RCS_STK_LAST : ptr_r - 3'h1;
  assign o_top  = entry[ptr_dn];

  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ptr_r <= {`RCS_STK_PTR_W{1'b0}};
    end else if (i_push) begin
      ptr_r <= ptr_up;
    end else if (i_pop) begin
      ptr_r <= ptr_dn;
    end
  end

  // Six 13-bit entries, each written only when the pointer selects it
  genvar g;
  generate
    for (g = 0; g < `RCS_STK_DEPTH; g = g + 1) begin : g_ent
      reg [`RCS_PC_W-1:0] val_r;
      always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          val_r <= `RCS_RESET_VEC;
        end else if (i_push && (ptr_r == g)) begin
          val_r <= i_push_data;
        end
      end
      assign entry[g] = val_r;
    end
  endgenerate

endmodule // rcs_stack
`default_nettype wire

// file: logic/rcs_core.v
`default_nettype none
`include "rcs_defines.vh"

module rcs_core (
  // Clock and reset
  input  wire                 i_sys_clk,
  input  wire                 i_reset_n,
  // Program ROM
  output wire [`RCS_PC_W-1:0] o_rom_addr,
  input  wire [`RCS_IR_W-1:0] i_rom_data,
  // File plane read
  output wire                 o_file_rd,
  output wire [6:0]           o_file_raddr,
  output wire                 o_file_rbank,
  input  wire [7:0]           i_file_rdata,
  // File plane write
  output reg                  o_file_we_r,
  output reg  [6:0]           o_file_waddr_r,
  output reg                  o_file_wbank_r,
  output reg  [7:0]           o_file_wdata_r,
  // Write-only plane
  output reg                  o_wo_we_r,
  output reg  [5:0]           o_wo_addr_r,
  output reg  [7:0]           o_wo_wdata_r,
  // Interrupt sources
  input  wire [7:0]           i_irq_event,
  input  wire [7:0]           i_irq_enable,
  // System
  output wire                 o_first_clock_phase,
  output wire                 o_second_clock_phase,
  output reg                  o_standby_r,
  output reg                  o_wdt_clear_r,
  output reg                  o_in_service_r
);

  reg  [`RCS_PC_W-1:0] program_counter_r;
  reg  [`RCS_PC_W-1:0] pc_nxt;
  reg  [`RCS_IR_W-1:0] ir_r;
  reg                  phase_r;
  reg                  bubble_r;
  reg                  iclr_pend_r;
  reg  [7:0]           acc_r;
  reg  [7:0]           status_r;
  reg  [7:0]           status_nxt;
  reg  [7:0]           indirect_pointer_register_r;
  reg  [7:0]           res;
  reg                  c_new;
  reg                  nc_new;
  reg                  fl_c;
  reg                  fl_nc;
  reg                  fl_z;
  reg                  wr_w;
  reg                  wr_file;
  reg                  skip;
  reg  [9:0]           sum;
  reg                  push;
  reg                  pop;
  reg  [`RCS_PC_W-1:0] push_data;
  wire [`RCS_PC_W-1:0] stack_top;

  // Add with carry in; gives {nibble carry, carry, sum}
  function [9:0] alu_add;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    reg   [4:0] lo;
    reg   [8:0] full;
    begin
      lo      = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      full    = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      alu_add = {lo[4], full[8], full[7:0]};
    end
  endfunction

  // Phase divider: the first phase executes, the second fetches
  wire ph_first = ~phase_r;
  assign o_first_clock_phase  = ph_first;
  assign o_second_clock_phase = phase_r;
  assign o_rom_addr           = program_counter_r;

  // Instruction forms
  wire       is_byte = (ir_r[13:12] == 2'b00);
  wire       is_bit  = (ir_r[13:11] == 3'b010);
  wire       is_lit  = (ir_r[13:11] == 3'b011);
  wire       is_jump = ir_r[13];
  wire       is_call = (ir_r[13:12] == 2'b10);
  wire [3:0] op      = ir_r[11:8];
  wire       dst     = ir_r[7];
  wire [2:0] bnum    = ir_r[8:6];
  wire [7:0] kval    = ir_r[7:0];
  wire       is_ctl  = is_byte && (op == `RCS_OP_MOVE) && !dst;
  wire       op_ret  = is_ctl && (ir_r[6:0] == `RCS_F_RET);
  wire       op_iret = is_ctl && (ir_r[6:0] == `RCS_F_IRET);
  wire       op_slp  = is_ctl && (ir_r[6:0] == `RCS_F_SLEEP);
  wire       op_wdt  = is_ctl && (ir_r[6:0] == `RCS_F_WDTCLR);
  wire       op_rtl  = is_lit && (ir_r[10:8] == `RCS_LIT_RET);
  // Codes 0, 3 and 4 belong to other opcodes, so those write-only slots are unreachable
  wire       op_mwr  = is_ctl && !ir_r[6] && (ir_r[6:0] != `RCS_F_NOP) &&
                       (ir_r[6:0] != `RCS_F_SLEEP) && (ir_r[6:0] != `RCS_F_WDTCLR);

  // Address zero goes through the pointer; bit operations see 00..3f only
  wire [6:0] fa  = is_bit ? {1'b0, ir_r[5:0]} : ir_r[6:0];
  wire [6:0] eff = (fa == `RCS_ADDR_IND) ? indirect_pointer_register_r[6:0] : fa;
  wire       at_st  = (eff == `RCS_ADDR_STATUS);
  wire       at_ptr = (eff == `RCS_ADDR_PTR);
  wire       at_pcl = (eff == `RCS_ADDR_PCL);
  wire [7:0] fval   = at_st ? status_r : at_ptr ? indirect_pointer_register_r :
                      at_pcl ? program_counter_r[7:0] : i_file_rdata;

  // Level request: any event flag with its enable set
  wire irq_pend = |(i_irq_event & i_irq_enable);
  wire active   = ph_first && !bubble_r && !o_standby_r;
  wire take_irq = active && irq_pend && !o_in_service_r;
  wire exec     = active && !take_irq;

  assign o_file_rd    = exec && ((is_byte && !is_ctl) || is_bit);
  assign o_file_raddr = eff;
  assign o_file_rbank = status_r[`RCS_ST_BANK];

  // ALU and destination selection
  always @* begin
    res    = 8'h00;
    sum    = 10'h000;
    c_new  = status_r[`RCS_ST_C];
    nc_new = status_r[`RCS_ST_NIB];
    fl_c   = 1'b0;
    fl_nc  = 1'b0;
    fl_z   = 1'b0;
    wr_w   = 1'b0;
    wr_file = 1'b0;
    skip   = 1'b0;
    if (is_byte && !is_ctl) begin
      wr_w    = !dst;
      wr_file = dst;
      case (op)
        `RCS_OP_MOVE: res = acc_r;
        `RCS_OP_CLR: begin
          res  = 8'h00;
          fl_z = 1'b1;
        end
        `RCS_OP_SUB: begin
          sum    = alu_add(fval, ~acc_r, 1'b1);
          res    = sum[7:0];
          c_new  = sum[8];
          nc_new = sum[9];
          {fl_c, fl_nc, fl_z} = 3'b111;
        end
        `RCS_OP_DEC: begin
          res  = fval - 8'h01;
          fl_z = 1'b1;
        end
        `RCS_OP_IOR: begin
          res  = fval | acc_r;
          fl_z = 1'b1;
        end
        `RCS_OP_AND: begin
          res  = fval & acc_r;
          fl_z = 1'b1;
        end
        `RCS_OP_XOR: begin
          res  = fval ^ acc_r;
          fl_z = 1'b1;
        end
        `RCS_OP_ADD: begin
          sum    = alu_add(fval, acc_r, 1'b0);
          res    = sum[7:0];
          c_new  = sum[8];
          nc_new = sum[9];
          {fl_c, fl_nc, fl_z} = 3'b111;
        end
        `RCS_OP_MOVF: begin
          res     = fval;
          fl_z    = dst;
          wr_file = 1'b0;
        end
        `RCS_OP_COM: begin
          res  = ~fval;
          fl_z = 1'b1;
        end
        `RCS_OP_INC: begin
          res  = fval + 8'h01;
          fl_z = 1'b1;
        end
        `RCS_OP_DECSZ: begin
          res  = fval - 8'h01;
          skip = (res == 8'h00);
        end
        `RCS_OP_RR: begin
          res   = {status_r[`RCS_ST_C], fval[7:1]};
          c_new = fval[0];
          fl_c  = 1'b1;
        end
        `RCS_OP_RL: begin
          res   = {fval[6:0], status_r[`RCS_ST_C]};
          c_new = fval[7];
          fl_c  = 1'b1;
        end
        `RCS_OP_SWAP: res = {fval[3:0], fval[7:4]};
        `RCS_OP_INCSZ: begin
          res  = fval + 8'h01;
          skip = (res == 8'h00);
        end
        default: res = 8'h00;
      endcase
    end else if (is_bit) begin
      case (ir_r[10:9])
        2'b00: begin
          res     = fval & ~(8'h01 << bnum);
          wr_file = 1'b1;
        end
        2'b01: begin
          res     = fval | (8'h01 << bnum);
          wr_file = 1'b1;
        end
        2'b10: skip = !fval[bnum];
        default: skip = fval[bnum];
      endcase
    end else if (is_lit) begin
      wr_w = 1'b1;
      case (ir_r[10:8])
        `RCS_LIT_RET: res = kval;
        `RCS_LIT_MOV: res = kval;
        `RCS_LIT_IOR: begin
          res  = acc_r | kval;
          fl_z = 1'b1;
        end
        `RCS_LIT_AND: begin
          res  = acc_r & kval;
          fl_z = 1'b1;
        end
        `RCS_LIT_ADD: begin
          sum    = alu_add(acc_r, kval, 1'b0);
          res    = sum[7:0];
          c_new  = sum[8];
          nc_new = sum[9];
          {fl_c, fl_nc, fl_z} = 3'b111;
        end
        `RCS_LIT_XOR: begin
          res  = acc_r ^ kval;
          fl_z = 1'b1;
        end
        default: wr_w = 1'b0;
      endcase
    end
  end

  // Status next value: all three flag bits of a status write are masked when the op owns any flag
  always @* begin
    status_nxt = status_r;
    if (exec && wr_file && at_st) begin
      status_nxt = res;
      if (fl_c || fl_nc || fl_z) begin
        status_nxt[2:0] = status_r[2:0];
      end
    end
    if (exec && fl_c) begin
      status_nxt[`RCS_ST_C] = c_new;
    end
    if (exec && fl_nc) begin
      status_nxt[`RCS_ST_NIB] = nc_new;
    end
    if (exec && fl_z) begin
      status_nxt[`RCS_ST_Z] = (res == 8'h00);
    end
  end

  // Next counter and stack strobes; a bubble or standby holds the counter so the fetch repeats
  always @* begin
    pc_nxt    = program_counter_r;
    push      = 1'b0;
    pop       = 1'b0;
    push_data = program_counter_r;
    if (take_irq) begin
      push   = 1'b1;
      pc_nxt = `RCS_INT_VEC;
    end else if (exec) begin
      if (is_jump) begin
        pc_nxt    = {status_r[`RCS_ST_PAGE], ir_r[11:0]};
        push      = is_call;
        push_data = program_counter_r + `RCS_PC_ONE;
      end else if (op_ret || op_iret || op_rtl) begin
        pc_nxt = stack_top;
        pop    = 1'b1;
      end else if (wr_file && at_pcl) begin
        pc_nxt = {program_counter_r[12:8], res};
      end else if (skip) begin
        pc_nxt = program_counter_r + `RCS_PC_TWO;
      end else begin
        pc_nxt = program_counter_r + `RCS_PC_ONE;
      end
    end
  end

  // Change of flow costs a second cycle that executes nothing
  wire flow = take_irq || (exec && (is_jump || op_ret || op_iret || op_rtl || skip ||
              (wr_file && at_pcl)));

  rcs_stack u_stack (
    .i_sys_clk   (i_sys_clk),
    .i_reset_n   (i_reset_n),
    .i_push      (push),
    .i_pop       (pop),
    .i_push_data (push_data),
    .o_top       (stack_top)
  );

  // Sequencer: execute and advance in the first phase, latch the word in the second
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_r           <= 1'b0;
      program_counter_r <= `RCS_RESET_VEC;
      ir_r              <= {`RCS_IR_W{1'b0}};
      bubble_r          <= 1'b1;
    end else begin
      phase_r <= ~phase_r;
      if (ph_first) begin
        program_counter_r <= pc_nxt;
        if (!o_standby_r) begin
          bubble_r <= flow;
        end
      end else begin
        ir_r <= i_rom_data;
      end
    end
  end

  // Working, status and pointer registers
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_r                       <= `RCS_W_RST;
      status_r                    <= `RCS_STATUS_RST;
      indirect_pointer_register_r <= `RCS_PTR_RST;
    end else begin
      status_r <= status_nxt;
      if (exec && wr_w) begin
        acc_r <= res;
      end
      if (exec && wr_file && at_ptr) begin
        indirect_pointer_register_r <= res;
      end
    end
  end

  // Write strobes stand through the second phase so the partner stores on its closing edge
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_file_we_r    <= 1'b0;
      o_file_waddr_r <= 7'h00;
      o_file_wbank_r <= 1'b0;
      o_file_wdata_r <= 8'h00;
      o_wo_we_r      <= 1'b0;
      o_wo_addr_r    <= 6'h00;
      o_wo_wdata_r   <= 8'h00;
      o_wdt_clear_r  <= 1'b0;
    end else begin
      o_file_we_r   <= exec && wr_file && !at_st && !at_ptr && !at_pcl;
      o_wo_we_r     <= exec && op_mwr;
      o_wdt_clear_r <= exec && op_wdt;
      if (exec && wr_file) begin
        o_file_waddr_r <= eff;
        o_file_wbank_r <= status_r[`RCS_ST_BANK];
        o_file_wdata_r <= res;
      end
      if (exec && op_mwr) begin
        o_wo_addr_r  <= ir_r[5:0];
        o_wo_wdata_r <= acc_r;
      end
    end
  end

  // Standby and in-service flag; any enabled request ends standby
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_standby_r    <= 1'b0;
      o_in_service_r <= 1'b0;
      iclr_pend_r    <= 1'b0;
    end else begin
      if (irq_pend) begin
        o_standby_r <= 1'b0;
      end else if (exec && op_slp) begin
        o_standby_r <= 1'b1;
      end
      if (take_irq) begin
        o_in_service_r <= 1'b1;
      end else if (exec && iclr_pend_r) begin
        o_in_service_r <= 1'b0;
        iclr_pend_r    <= 1'b0;
      end else if (exec && op_iret) begin
        iclr_pend_r <= 1'b1;
      end
    end
  end

endmodule // rcs_core
`default_nettype wire

// file: verif/rcs_core_assertions.sv
`default_nettype none
module rcs_core_assertions (
  // Clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_reset_n,
  // Core outputs and interrupt inputs
  input wire logic [12:0] o_rom_addr,
  input wire logic        o_file_rd,
  input wire logic        o_file_we_r,
  input wire logic [6:0]  o_file_waddr_r,
  input wire logic        o_wo_we_r,
  input wire logic [7:0]  i_irq_event,
  input wire logic [7:0]  i_irq_enable,
  input wire logic        o_first_clock_phase,
  input wire logic        o_second_clock_phase,
  input wire logic        o_standby_r,
  input wire logic        o_wdt_clear_r,
  input wire logic        o_in_service_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // Single domain, so clock and reset are stated once
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  phase_alternate_a: assert property (o_first_clock_phase |=> !o_first_clock_phase ##1 o_first_clock_phase)
    else $error("phases do not alternate");
  phase_complement_a: assert property (o_first_clock_phase != o_second_clock_phase)
    else $error("phases overlap");
  counter_edge_a: assert property ($changed(o_rom_addr) |-> $past(o_first_clock_phase))
    else $error("counter moved outside first phase");
  read_phase_a: assert property (o_file_rd |-> o_first_clock_phase && !o_standby_r)
    else $error("file read outside first phase");
  write_pulse_a: assert property (o_file_we_r |-> o_second_clock_phase ##1 !o_file_we_r)
    else $error("file write not a second phase pulse");
  wo_pulse_a: assert property (o_wo_we_r |-> o_second_clock_phase && !o_file_we_r)
    else $error("write-only strobe misplaced");
  internal_regs_a: assert property (o_file_we_r |-> !(o_file_waddr_r inside {7'h02, 7'h03, 7'h04}))
    else $error("internal register leaked as a write");
  int_vector_a: assert property ($rose(o_in_service_r) |-> o_rom_addr == 13'h0001)
    else $error("service did not start at vector");
  int_enabled_a: assert property ($rose(o_in_service_r) |-> $past((i_irq_event & i_irq_enable) != 8'h00))
    else $error("service without enabled event");
  wdt_pulse_a: assert property (o_wdt_clear_r |=> !o_wdt_clear_r)
    else $error("watchdog clear longer than a pulse");
  standby_hold_a: assert property (o_standby_r && $past(o_standby_r) |-> $stable(o_rom_addr) && !o_file_we_r)
    else $error("activity during standby");
endmodule // rcs_core_assertions

bind rcs_core rcs_core_assertions i_rcs_core_assertions (
  .i_sys_clk, .i_reset_n, .o_rom_addr, .o_file_rd, .o_file_we_r, .o_file_waddr_r, .o_wo_we_r,
  .i_irq_event, .i_irq_enable, .o_first_clock_phase, .o_second_clock_phase, .o_standby_r,
  .o_wdt_clear_r, .o_in_service_r
);
`default_nettype wire

// file: verif/rcs_mem_model.sv
`default_nettype none
module rcs_mem_model (
  // Clock
  input  wire logic        i_sys_clk,
  // Program ROM
  input  wire logic [12:0] i_rom_addr,
  output logic      [13:0] o_rom_data,
  // File plane
  input  wire logic        i_file_rd,
  input  wire logic [6:0]  i_file_raddr,
  input  wire logic        i_file_rbank,
  output logic      [7:0]  o_file_rdata,
  input  wire logic        i_file_we,
  input  wire logic [6:0]  i_file_waddr,
  input  wire logic        i_file_wbank,
  input  wire logic [7:0]  i_file_wdata,
  // Write-only plane
  input  wire logic        i_wo_we,
  input  wire logic [5:0]  i_wo_addr,
  input  wire logic [7:0]  i_wo_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] rom [0:8191];
  logic [7:0]  ram [0:255];
  logic [7:0]  last_r = 8'h00;
  logic [16:0] log_q [$];
  // Combinational ROM; an idle read bus shows the inverse of the last byte so stale data cannot pass
  assign o_rom_data = rom[i_rom_addr];
  assign o_file_rdata = i_file_rd ? ram[{i_file_rbank & (i_file_raddr >= 7'h20), i_file_raddr}] : ~last_r;
  // File writes land in RAM and in the log; registers below 20 are shared by both banks
  always @(posedge i_sys_clk) begin
    if (i_file_rd) last_r <= o_file_rdata;
    if (i_file_we) begin
      ram[{i_file_wbank & (i_file_waddr >= 7'h20), i_file_waddr}] <= i_file_wdata;
      log_q.push_back({1'b0, i_file_wbank, i_file_waddr, i_file_wdata});
    end
    if (i_wo_we) log_q.push_back({3'b100, i_wo_addr, i_wo_wdata});
  end
endmodule // rcs_mem_model
`default_nettype wire

// file: verif/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  `define check(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
  logic        i_sys_clk, i_reset_n;
  logic [12:0] o_rom_addr;
  logic [13:0] i_rom_data;
  logic        o_file_rd, o_file_rbank, o_file_we_r, o_file_wbank_r, o_wo_we_r;
  logic [6:0]  o_file_raddr, o_file_waddr_r;
  logic [7:0]  i_file_rdata, o_file_wdata_r, o_wo_wdata_r, i_irq_event, i_irq_enable;
  logic [5:0]  o_wo_addr_r;
  logic        o_first_clock_phase, o_second_clock_phase, o_standby_r, o_wdt_clear_r, o_in_service_r;
  logic        svc_ok = 1'b1;
  logic [12:0] hold;
  integer      errors = 0;
  integer      tests_run = 0;
  integer      wdt_cnt = 0;
  integer      hits = 0;
  integer      n;
  // Program as {address, word}; vector 1 jumps to the handler at 300, which returns from 302
  // Page-one code jumps by a counter-low write, then runs a taken skip and a flag-owning status clear
  localparam logic [31:0] PROG [43] = '{
    32'h00003010, 32'h00013300, 32'h0010195a, 32'h001100a5, 32'h001207a5, 32'h00130010, 32'h00141930,
    32'h00150084, 32'h00161977, 32'h00170080, 32'h00182200, 32'h001900a7, 32'h001a1303, 32'h001b00c5,
    32'h001c1103, 32'h001d1901, 32'h001e0225, 32'h001f0803, 32'h002000a8, 32'h00211383, 32'h00223040,
    32'h02001911, 32'h020100a6, 32'h02021822, 32'h10401183, 32'h104100a9, 32'h10421960, 32'h10430082,
    32'h10601901, 32'h106100ac, 32'h10620bac, 32'h106300ad, 32'h10640183, 32'h10650803, 32'h106600ae,
    32'h10673050, 32'h00500004, 32'h00510003, 32'h005200aa, 32'h00533053, 32'h03001999, 32'h030100ab,
    32'h03020060};
  // Expected writes as {write-only, bank, address, data}; 2e07 shows the status clear kept C and nibble carry
  localparam logic [16:0] EXP [15] = '{17'h0255a, 17'h025b4, 17'h1105a, 17'h03077, 17'h02611, 17'h02722,
    17'h0c522, 17'h02803, 17'h02903, 17'h02c01, 17'h02c00, 17'h02e07, 17'h02b99, 17'h02a99, 17'h02b99};

  rcs_core i_rcs_core (
    .i_sys_clk, .i_reset_n, .o_rom_addr, .i_rom_data, .o_file_rd, .o_file_raddr, .o_file_rbank,
    .i_file_rdata, .o_file_we_r, .o_file_waddr_r, .o_file_wbank_r, .o_file_wdata_r, .o_wo_we_r,
    .o_wo_addr_r, .o_wo_wdata_r, .i_irq_event, .i_irq_enable, .o_first_clock_phase,
    .o_second_clock_phase, .o_standby_r, .o_wdt_clear_r, .o_in_service_r);
  rcs_mem_model i_rcs_mem_model (
    .i_sys_clk, .i_rom_addr(o_rom_addr), .o_rom_data(i_rom_data), .i_file_rd(o_file_rd),
    .i_file_raddr(o_file_raddr), .i_file_rbank(o_file_rbank), .o_file_rdata(i_file_rdata),
    .i_file_we(o_file_we_r), .i_file_waddr(o_file_waddr_r), .i_file_wbank(o_file_wbank_r),
    .i_file_wdata(o_file_wdata_r), .i_wo_we(o_wo_we_r), .i_wo_addr(o_wo_addr_r), .i_wo_wdata(o_wo_wdata_r));

  // 125 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic step(input integer k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Handler writes: the first leaves the event up so the level retakes it, the second clears it
  always @(posedge i_sys_clk) begin
    if (o_wdt_clear_r === 1'b1) wdt_cnt <= wdt_cnt + 1;
    if (o_file_we_r === 1'b1 && o_file_waddr_r === 7'h2b) begin
      hits <= hits + 1;
      svc_ok <= svc_ok & o_in_service_r;
      if (hits == 1) i_irq_event <= #1 8'h00;
    end
  end

  // Main sequence; the event waits masked until the core is in standby
  initial begin
    i_reset_n = 1'b0;
    i_irq_event = 8'h01;
    i_irq_enable = 8'h00;
    foreach (PROG[i]) i_rcs_mem_model.rom[PROG[i][28:16]] = PROG[i][13:0];
    step(20);
    `check(o_rom_addr, 13'h0000)
    `check({o_standby_r, o_in_service_r}, 2'b00)
    i_reset_n = 1'b1;
    for (n = 0; n < 400 && o_standby_r !== 1'b1; n++) step(1);
    `check(o_standby_r, 1'b1)
    hold = o_rom_addr;
    step(20);
    `check(o_rom_addr, hold)
    `check(wdt_cnt, 1)
    i_irq_enable = 8'h01;
    for (n = 0; n < 300 && i_rcs_mem_model.log_q.size() < 15; n++) step(1);
    step(20);
    `check(i_rcs_mem_model.log_q.size(), 15)
    foreach (EXP[i]) `check(i_rcs_mem_model.log_q[i], EXP[i])
    `check(svc_ok, 1'b1)
    `check(o_in_service_r, 1'b0)
    finish_test;
  end

  // Watchdog on the whole run
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    errors++;
    $display("Watchdog expired at %0t", $time);
    finish_test;
  end
endmodule // testbench
`default_nettype wire
